// >>> pkg/mpfc_pkg.sv
// Shared constants for the per-port MAC pause and backpressure logic.
// Assumes a 40 MHz core clock and a byte-wide transmit and receive stream.
package mpfc_pkg;
    localparam int unsigned CLK_MHZ = 40;
    // Pause quantum in bit times.
    localparam int unsigned QUANTUM_BITS = 512;
    // Bit time in picoseconds at each speed.
    localparam int unsigned BIT_PS_10M = 100000;
    localparam int unsigned BIT_PS_100M = 10000;
    localparam int unsigned CLK_PS = 1000000 / CLK_MHZ;
    // Cycles per quantum, rounded down so a quantum is never stretched.
    localparam int unsigned QCYC_10M = (QUANTUM_BITS * BIT_PS_10M) / CLK_PS;
    localparam int unsigned QCYC_100M = (QUANTUM_BITS * BIT_PS_100M) / CLK_PS;
    // Resend point as a percentage of the advertised pause.
    localparam int unsigned RESEND_PCT = 80;
    // Pause frame field values.
    localparam logic [47:0] PAUSE_DA = 48'h0180C2000001;
    localparam logic [15:0] CTRL_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    // Frame lengths in bytes, CRC included.
    localparam logic [10:0] TX_FRAME_LEN = 11'h040;
    localparam logic [10:0] RX_MIN_LEN = 11'h040;
    localparam logic [10:0] RX_MAX_LEN = 11'h5FB;
    localparam logic [10:0] CRC_START = 11'h03C;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY_R = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
endpackage

// >>> hw/mpfc_pause_gen.sv
// Byte serialiser for one 64-byte pause frame with CRC.
// Assumes the consumer accepts a byte whenever tx_ready is high.
`timescale 1ns/1ps
`default_nettype none
module mpfc_pause_gen
    import mpfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [47:0] src_addr,
    input wire logic [15:0] pause_time,
    input wire logic tx_ready,
    output logic busy,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic tx_last
);
    typedef struct packed {
        logic busy;
        logic [10:0] idx;
        logic [31:0] crc;
        logic [47:0] sa;
        logic [15:0] pt;
        logic [7:0] ob;
        logic last;
    } mpfc_gen_t;
    mpfc_gen_t s_reg, s_next;
    logic [7:0] cur_byte;

    // Bytewise reflected CRC update so byte bits go out lsb first.
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY_R) : (r >> 1);
        end
        return r;
    endfunction

    // Header fields go out most significant byte first; rest is zero pad.
    // The CRC is sent inverted, low byte first, as the reflected form needs.
    function automatic logic [7:0] frame_byte(input logic [10:0] i, input logic [47:0] sa,
                                              input logic [15:0] pt, input logic [31:0] c);
        logic [7:0] b;
        unique case (i)
            11'h000: b = PAUSE_DA[47:40];
            11'h001: b = PAUSE_DA[39:32];
            11'h002: b = PAUSE_DA[31:24];
            11'h003: b = PAUSE_DA[23:16];
            11'h004: b = PAUSE_DA[15:8];
            11'h005: b = PAUSE_DA[7:0];
            11'h006: b = sa[47:40];
            11'h007: b = sa[39:32];
            11'h008: b = sa[31:24];
            11'h009: b = sa[23:16];
            11'h00A: b = sa[15:8];
            11'h00B: b = sa[7:0];
            11'h00C: b = CTRL_TYPE[15:8];
            11'h00D: b = CTRL_TYPE[7:0];
            11'h00E: b = PAUSE_OPCODE[15:8];
            11'h00F: b = PAUSE_OPCODE[7:0];
            11'h010: b = pt[15:8];
            11'h011: b = pt[7:0];
            default: b = 8'h00;
        endcase
        if (i >= CRC_START) begin
            b = ~c[8 * i[1:0] +: 8];
        end
        return b;
    endfunction

    // The byte on offer feeds the CRC; the next one is registered so the output leaves a flop.
    assign cur_byte = frame_byte(s_reg.idx, s_reg.sa, s_reg.pt, s_reg.crc);

    // Frame sequencing; exactly 64 bytes leave per start.
    always_comb begin
        s_next = s_reg;
        if (!s_reg.busy && start) begin
            s_next.busy = 1'b1;
            s_next.idx = 11'h000;
            s_next.crc = CRC_INIT;
            s_next.sa = src_addr;
            s_next.pt = pause_time;
        end else if (s_reg.busy && tx_ready) begin
            if (s_reg.idx < CRC_START) begin
                s_next.crc = crc_step(s_reg.crc, cur_byte);
            end
            s_next.idx = s_reg.idx + 11'h001;
            if (s_reg.idx == TX_FRAME_LEN - 11'h001) begin
                s_next.busy = 1'b0;
            end
        end
        s_next.ob = frame_byte(s_next.idx, s_next.sa, s_next.pt, s_next.crc);
        s_next.last = s_next.busy && (s_next.idx == TX_FRAME_LEN - 11'h001);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.busy;
    assign tx_valid = s_reg.busy;
    assign tx_byte = s_reg.ob;
    assign tx_last = s_reg.last;
endmodule
`default_nettype wire

// >>> hw/mpfc_port.sv
// Per-port flow control: backpressure, pause transmit and pause receive.
// Assumes a byte-wide receive stream with frame end and CRC status in step.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Congestion asserts flow control; relief releases it
// - Full duplex: collision input blocks new starts
// - Forced collisions uncapped, independent of backoff
// - Pause frame carries fixed DA, type, opcode
// - Pause quantum is 512 bit times
// - Fields sent msb-byte first, lsb-bit first
// - Accept 64..1531 byte pauses; send 64
// - Source address from device node address
// - Send pause: enable, full duplex, global
// - Honour pauses when pause or pausetx set
// - Absorb every 88.08 frame, never forward
// - Count control frames in MAC stats only
// - Pause acts only if valid in every way
// - Load timer from bytes after opcode
// - Foreign destination while running expires timer
// - Zero pause time while running expires timer
// - Otherwise reload timer with new time
// - Pause enable dropping expires timer
// - Hold new data frames while timer runs
// - Congestion sends pause at first opportunity
// - Resend after 80 percent of interval
// - Zero pause-time register blocks pause frames
module mpfc_port
    import mpfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [15:0] free_buffers,
    input wire logic [15:0] flow_threshold,
    input wire logic flow_enable,
    input wire logic pause_enable,
    input wire logic pause_tx_enable,
    input wire logic full_duplex,
    input wire logic speed_100,
    input wire logic [15:0] pause_time_10,
    input wire logic [15:0] pause_time_100,
    input wire logic [47:0] node_addr,
    input wire logic collision_in,
    input wire logic data_tx_req,
    input wire logic data_tx_busy,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    input wire logic rx_crc_ok,
    input wire logic port_receive_error,
    input wire logic tx_ready,
    output logic data_tx_start,
    output logic force_collision,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic tx_last,
    output logic rx_forward,
    output logic rx_discard,
    output logic rx_learn,
    output logic mac_stat_frame,
    output logic paused
);
    typedef enum logic [1:0] {
        TXS_IDLE = 2'b00,
        TXS_WAIT = 2'b01,
        TXS_PAUSE = 2'b11
    } mpfc_txs_t;

    typedef struct packed {
        mpfc_txs_t txs;
        logic [10:0] rx_cnt;
        logic [47:0] rx_da;
        logic [15:0] rx_type;
        logic [15:0] rx_op;
        logic [15:0] rx_pt;
        logic rx_err;
        logic [15:0] ptimer;
        logic [11:0] qdiv;
        logic [15:0] resend;
        logic [11:0] rqdiv;
        logic pause_en_d;
        logic data_tx_start;
        logic force_collision;
        logic rx_forward;
        logic rx_discard;
        logic rx_learn;
        logic mac_stat_frame;
        logic paused;
        logic gen_start;
    } mpfc_port_t;

    mpfc_port_t s_reg, s_next;
    logic gen_busy;
    logic [15:0] cur_pt;
    logic [15:0] pt_80;
    logic [11:0] qlen;
    logic congested;
    logic may_send;
    logic honour;
    logic pause_valid;
    logic da_ok;

    // Number of core cycles in one quantum at a given speed.
    function automatic logic [11:0] quantum_cycles(input logic fast);
        return fast ? 12'(QCYC_100M) : 12'(QCYC_10M);
    endfunction

    mpfc_pause_gen u_gen (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(s_reg.gen_start),
        .src_addr(node_addr),
        .pause_time(cur_pt),
        .tx_ready(tx_ready),
        .busy(gen_busy),
        .tx_byte(tx_byte),
        .tx_valid(tx_valid),
        .tx_last(tx_last)
    );

    // Conditions shared by the transmit and receive halves.
    always_comb begin
        cur_pt = speed_100 ? pause_time_100 : pause_time_10;
        pt_80 = 16'((32'(cur_pt) * RESEND_PCT) / 100);
        qlen = quantum_cycles(speed_100);
        congested = (free_buffers < flow_threshold);
        may_send = pause_enable && full_duplex && flow_enable && (cur_pt != 16'h0000);
        honour = pause_enable || pause_tx_enable;
        da_ok = (s_reg.rx_da == PAUSE_DA) || (s_reg.rx_da == node_addr);
        pause_valid = honour && (s_reg.rx_type == CTRL_TYPE) && (s_reg.rx_op == PAUSE_OPCODE)
            && (s_reg.rx_cnt >= RX_MIN_LEN) && (s_reg.rx_cnt <= RX_MAX_LEN)
            && !s_reg.rx_err && !port_receive_error && rx_crc_ok;
    end

    // Receive parser, pause timer, pause transmit scheduler and data gating.
    always_comb begin
        s_next = s_reg;
        s_next.gen_start = 1'b0;
        s_next.rx_forward = 1'b0;
        s_next.rx_discard = 1'b0;
        s_next.rx_learn = 1'b0;
        s_next.mac_stat_frame = 1'b0;
        s_next.data_tx_start = 1'b0;
        s_next.pause_en_d = pause_enable;

        // Header capture; bytes shift in msb first for each field.
        if (rx_valid) begin
            if (s_reg.rx_cnt != 11'h7FF) begin
                s_next.rx_cnt = s_reg.rx_cnt + 11'h001;
            end
            if (port_receive_error) begin
                s_next.rx_err = 1'b1;
            end
            if (s_reg.rx_cnt < 11'h006) begin
                s_next.rx_da = {s_reg.rx_da[39:0], rx_data};
            end else if (s_reg.rx_cnt >= 11'h00C && s_reg.rx_cnt < 11'h00E) begin
                s_next.rx_type = {s_reg.rx_type[7:0], rx_data};
            end else if (s_reg.rx_cnt >= 11'h00E && s_reg.rx_cnt < 11'h010) begin
                s_next.rx_op = {s_reg.rx_op[7:0], rx_data};
            end else if (s_reg.rx_cnt >= 11'h010 && s_reg.rx_cnt < 11'h012) begin
                s_next.rx_pt = {s_reg.rx_pt[7:0], rx_data};
            end
        end

        // Quantum tick drives the countdown; expired means zero.
        if (s_reg.ptimer != 16'h0000) begin
            if (s_reg.qdiv + 12'h001 >= qlen) begin
                s_next.qdiv = 12'h000;
                s_next.ptimer = s_reg.ptimer - 16'h0001;
            end else begin
                s_next.qdiv = s_reg.qdiv + 12'h001;
            end
        end

        // Frame end: absorb control frames, act on valid pauses.
        if (rx_end) begin
            s_next.rx_cnt = 11'h000;
            s_next.rx_err = 1'b0;
            // A stale type would brand a runt next frame as control.
            s_next.rx_type = 16'h0000;
            s_next.mac_stat_frame = 1'b1;
            if (s_reg.rx_type == CTRL_TYPE) begin
                s_next.rx_discard = 1'b1;
            end else begin
                s_next.rx_forward = 1'b1;
                s_next.rx_learn = 1'b1;
            end
            if (pause_valid) begin
                s_next.qdiv = 12'h000;
                if (s_reg.ptimer != 16'h0000 && !da_ok) begin
                    s_next.ptimer = 16'h0000;
                end else if (s_reg.ptimer != 16'h0000 && s_reg.rx_pt == 16'h0000) begin
                    s_next.ptimer = 16'h0000;
                end else begin
                    s_next.ptimer = s_reg.rx_pt;
                end
            end
        end

        // Losing pause enable cancels any pause in force.
        if (s_reg.pause_en_d && !pause_enable) begin
            s_next.ptimer = 16'h0000;
        end
        s_next.paused = (s_next.ptimer != 16'h0000);

        // Resend countdown in quanta of the advertised pause.
        if (s_reg.resend != 16'h0000) begin
            if (s_reg.rqdiv + 12'h001 >= qlen) begin
                s_next.rqdiv = 12'h000;
                s_next.resend = s_reg.resend - 16'h0001;
            end else begin
                s_next.rqdiv = s_reg.rqdiv + 12'h001;
            end
        end

        // Pause transmit scheduler; waits for any data frame to finish.
        unique case (s_reg.txs)
            TXS_IDLE: begin
                if (congested && may_send && s_reg.resend == 16'h0000) begin
                    s_next.txs = TXS_WAIT;
                end
            end
            TXS_WAIT: begin
                if (!may_send || !congested) begin
                    s_next.txs = TXS_IDLE;
                end else if (!data_tx_busy && !gen_busy) begin
                    s_next.gen_start = 1'b1;
                    s_next.resend = (pt_80 == 16'h0000) ? 16'h0001 : pt_80;
                    s_next.rqdiv = 12'h000;
                    s_next.txs = TXS_PAUSE;
                end
            end
            TXS_PAUSE: begin
                if (!gen_busy && !s_reg.gen_start) begin
                    s_next.txs = TXS_IDLE;
                end
            end
        endcase
        if (!congested) begin
            s_next.resend = 16'h0000;
        end

        // Data frames wait for pause, collision in full duplex, and own pause.
        if (data_tx_req && !data_tx_busy && !gen_busy && s_reg.txs == TXS_IDLE
            && !s_reg.paused
            && !(full_duplex && collision_in)) begin
            s_next.data_tx_start = 1'b1;
        end

        // Half duplex backpressure holds while congested with no attempt limit.
        s_next.force_collision = congested && flow_enable && !full_duplex;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign data_tx_start = s_reg.data_tx_start;
    assign force_collision = s_reg.force_collision;
    assign rx_forward = s_reg.rx_forward;
    assign rx_discard = s_reg.rx_discard;
    assign rx_learn = s_reg.rx_learn;
    assign mac_stat_frame = s_reg.mac_stat_frame;
    assign paused = s_reg.paused;
endmodule
`default_nettype wire

// >>> tb/mpfc_port_checker.sv
// Concurrent checks on the ports of the per-port pause and backpressure block.
// Assumes it is bound to mpfc_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module mpfc_port_checker
    import mpfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [15:0] free_buffers,
    input wire logic [15:0] flow_threshold,
    input wire logic flow_enable,
    input wire logic pause_enable,
    input wire logic full_duplex,
    input wire logic collision_in,
    input wire logic tx_ready,
    input wire logic data_tx_start,
    input wire logic force_collision,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic rx_forward,
    input wire logic rx_discard,
    input wire logic rx_learn,
    input wire logic mac_stat_frame,
    input wire logic paused
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic cong_hd;
    logic [6:0] nbyte_reg;
    // Half-duplex congestion is the only case that calls for forced collisions.
    assign cong_hd = flow_enable && !full_duplex && (free_buffers < flow_threshold);
    // Counts accepted pause bytes; it restarts after the last one so frames are judged alone.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || (tx_valid && tx_ready && tx_last)) nbyte_reg <= 7'h00;
        else if (tx_valid && tx_ready) nbyte_reg <= nbyte_reg + 7'h01;
    end
    sequence s_hd_cong;
        cong_hd ##1 cong_hd;
    endsequence
    sequence s_relief;
        !cong_hd ##1 !cong_hd;
    endsequence
    bp_apply_a: assert property (s_hd_cong |-> force_collision) else $error("backpressure missing");
    bp_release_a: assert property (s_relief |-> !force_collision) else $error("backpressure stuck");
    fd_collide_a: assert property (full_duplex && collision_in |=> !data_tx_start) else $error("start in collision");
    hold_paused_a: assert property (paused |=> !data_tx_start) else $error("start while paused");
    absorb_ctrl_a: assert property (rx_discard |-> !rx_forward && !rx_learn && mac_stat_frame)
        else $error("control frame leaked");
    first_byte_a: assert property ($rose(tx_valid) |-> tx_byte == PAUSE_DA[47:40]) else $error("bad first byte");
    frame_len_a: assert property (tx_valid && tx_ready && tx_last |-> nbyte_reg == 7'h3F)
        else $error("pause frame length");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("byte dropped");
    gen_gate_a: assert property ($rose(tx_valid) |-> flow_enable && pause_enable && full_duplex)
        else $error("pause sent while disabled");
    drop_expire_a: assert property ($fell(pause_enable) |=> !paused) else $error("timer kept running");
endmodule
bind mpfc_port mpfc_port_checker u_chk (.*);
`default_nettype wire

// >>> tb/mpfc_peer.sv
// Link partner model: feeds frames into the receive stream and takes pause bytes.
// Assumes the bench calls send from one process, one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module mpfc_peer (
    input wire logic sys_clk,
    input wire logic slow,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end,
    output logic rx_crc_ok,
    output logic port_receive_error,
    output logic tx_ready
);
    logic [1:0] tick;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hA5;
        rx_end = 1'b0;
        rx_crc_ok = 1'b0;
        port_receive_error = 1'b0;
        tx_ready = 1'b1;
        tick = 2'h0;
    end
    // A slow partner stalls one byte in three, so the sender must hold its byte.
    always @(posedge sys_clk) begin
        tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
        tx_ready <= #1 !slow || (tick != 2'h0);
    end
    // One frame, header msb byte first, zero padding, then the end pulse with CRC status.
    task automatic send(input logic [47:0] da, input logic [31:0] tyop, input logic [15:0] pt,
                        input int len, input logic crc, input logic err);
        logic [143:0] h;
        h = {da, 48'h020000A1B2C3, tyop, pt};
        for (int i = 0; i < len; i++) begin
            @(posedge sys_clk);
            #1;
            rx_valid = 1'b1;
            rx_data = (i < 18) ? h[143 - 8 * i -: 8] : 8'h00;
            port_receive_error = err && (i == 20);
        end
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        rx_end = 1'b1;
        rx_crc_ok = crc;
        @(posedge sys_clk);
        #1;
        rx_end = 1'b0;
        rx_crc_ok = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/mpfc_port_test.sv
// Self-checking bench for mpfc_port with the link partner model on its far side.
// Assumes the checker is bound in; all stimulus lands 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module mpfc_port_test
    import mpfc_pkg::*;
;
    logic sys_clk = 1'b0, rst_b, flow_enable, pause_enable, pause_tx_enable, full_duplex, speed_100, slow;
    logic collision_in, data_tx_req, data_tx_busy, rx_valid, rx_end, rx_crc_ok, port_receive_error, tx_ready;
    logic data_tx_start, force_collision, tx_valid, tx_last, rx_forward, rx_discard, rx_learn, mac_stat_frame, paused;
    logic [15:0] free_buffers, flow_threshold, pause_time_10, pause_time_100;
    logic [47:0] node_addr;
    logic [7:0] rx_data, tx_byte;
    logic [31:0] seed = 32'h0000E4DD;
    logic [3:0] cfg [4] = '{4'h7, 4'hB, 4'hD, 4'hE};
    logic [3:0] exp_rx [$];
    logic [7:0] exp_tx [$];
    int fail_count = 0, n_checks = 0, n;
    mpfc_port u_dut (.*);
    mpfc_peer u_peer (.*);
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic rx(input logic [47:0] da, input logic [31:0] tyop, input logic [15:0] pt,
                      input int len, input logic crc, input logic err);
        exp_rx.push_back((tyop[31:16] == CTRL_TYPE) ? 4'h5 : 4'hB);
        u_peer.send(da, tyop, pt, len, crc, err);
    endtask
    // Sends one pause, checks whether it took hold, then clears it with a zero time.
    task automatic tp(input logic [47:0] da, input logic [15:0] op, input int len, input logic crc,
                      input logic err, input logic exp);
        rx(da, {CTRL_TYPE, op}, 16'h0003, len, crc, err);
        step(3);
        check(paused, exp);
        rx(PAUSE_DA, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0000, 64, 1'b1, 1'b0);
        step(3);
        check(paused, 1'b0);
    endtask
    task automatic wait_start(input logic exp);
        logic seen;
        seen = 1'b0;
        // The first edge still shows the answer to the previous inputs.
        @(posedge sys_clk);
        repeat (20) begin
            @(posedge sys_clk);
            if (data_tx_start === 1'b1) seen = 1'b1;
        end
        #1;
        check(seen, exp);
    endtask
    // Expected pause frame: header, zero pad to 60 bytes, CRC lsb byte first.
    task automatic push_pause(input logic [15:0] pt);
        logic [143:0] h;
        logic [31:0] c;
        logic [7:0] b;
        h = {PAUSE_DA, node_addr, CTRL_TYPE, PAUSE_OPCODE, pt};
        c = CRC_INIT;
        for (int i = 0; i < 60; i++) begin
            b = (i < 18) ? h[143 - 8 * i -: 8] : 8'h00;
            exp_tx.push_back(b);
            c = c ^ {24'h000000, b};
            repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY_R) : (c >> 1);
        end
        for (int i = 0; i < 4; i++) exp_tx.push_back(~c[8 * i +: 8]);
    endtask
    // Every result pulse or accepted byte takes the oldest note; one with no note is a mismatch.
    always @(posedge sys_clk) begin
        if (rst_b === 1'b1 && {rx_forward, rx_discard, rx_learn, mac_stat_frame} !== 4'h0) begin
            if (exp_rx.size() == 0) check(1, 0);
            else check({rx_forward, rx_discard, rx_learn, mac_stat_frame}, exp_rx.pop_front());
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_tx.size() == 0) check(1, 0);
            else begin
                check(tx_last, exp_tx.size() == 1);
                check(tx_byte, exp_tx.pop_front());
            end
        end
    end
    // A hang runs out well beyond the expected length of the run.
    initial begin
        #(25 * 40000);
        fail_count++;
        close_out();
    end
    initial begin
        {rst_b, flow_enable, pause_tx_enable, collision_in, data_tx_busy, slow} = 6'h00;
        {pause_enable, full_duplex, speed_100, data_tx_req} = 4'hF;
        {free_buffers, flow_threshold, pause_time_10, pause_time_100} = {16'h0040, 16'h0020, 16'h0001, 16'h0003};
        seed = lfsr(seed);
        node_addr = {seed[15:0], lfsr(seed)};
        step(16);
        rst_b = 1'b1;
        check({paused, tx_valid, force_collision}, 3'h0);
        rx(48'h0A0000000001, 32'h08000000, 16'h0000, 64, 1'b1, 1'b0);
        tp(PAUSE_DA, PAUSE_OPCODE, 64, 1'b1, 1'b0, 1'b1);
        tp(node_addr, PAUSE_OPCODE, 1531, 1'b1, 1'b0, 1'b1);
        tp(PAUSE_DA, PAUSE_OPCODE, 63, 1'b1, 1'b0, 1'b0);
        tp(PAUSE_DA, PAUSE_OPCODE, 1532, 1'b1, 1'b0, 1'b0);
        tp(PAUSE_DA, PAUSE_OPCODE, 64, 1'b0, 1'b0, 1'b0);
        tp(PAUSE_DA, PAUSE_OPCODE, 64, 1'b1, 1'b1, 1'b0);
        tp(PAUSE_DA, 16'h0002, 64, 1'b1, 1'b0, 1'b0);
        {pause_enable, pause_tx_enable} = 2'h1;
        tp(PAUSE_DA, PAUSE_OPCODE, 64, 1'b1, 1'b0, 1'b1);
        pause_tx_enable = 1'b0;
        tp(PAUSE_DA, PAUSE_OPCODE, 64, 1'b1, 1'b0, 1'b0);
        pause_enable = 1'b1;
        rx(PAUSE_DA, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0003, 64, 1'b1, 1'b0);
        step(400);
        check(paused, 1'b1);
        wait_start(1'b0);
        step(210);
        check(paused, 1'b0);
        wait_start(1'b1);
        rx(PAUSE_DA, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0008, 64, 1'b1, 1'b0);
        step(100);
        rx(PAUSE_DA, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0001, 64, 1'b1, 1'b0);
        step(230);
        check(paused, 1'b0);
        rx(PAUSE_DA, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0008, 64, 1'b1, 1'b0);
        rx(48'h0A0000000001, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0008, 64, 1'b1, 1'b0);
        step(2);
        check(paused, 1'b0);
        rx(PAUSE_DA, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0008, 64, 1'b1, 1'b0);
        pause_enable = 1'b0;
        step(2);
        check(paused, 1'b0);
        {pause_enable, collision_in, full_duplex} = 3'h6;
        wait_start(1'b1);
        full_duplex = 1'b1;
        wait_start(1'b0);
        collision_in = 1'b0;
        // Congestion with a slow partner: one pause, then a resend after 2 quanta, 80 percent of 3 rounded down.
        {slow, flow_enable} = 2'h3;
        push_pause(16'h0003);
        data_tx_busy = 1'b1;
        free_buffers = 16'h001F;
        step(50);
        check(tx_valid, 1'b0);
        data_tx_busy = 1'b0;
        n = 0;
        while (exp_tx.size() != 0 && n < 2000) begin
            step(1);
            n++;
        end
        check(n < 2000, 1);
        push_pause(16'h0003);
        n = 0;
        while (tx_valid !== 1'b1 && n < 1000) begin
            step(1);
            n++;
        end
        check((n > 250) && (n < 420), 1);
        step(150);
        free_buffers = 16'h0040;
        step(600);
        for (int i = 0; i < 4; i++) begin
            {pause_enable, full_duplex, flow_enable, speed_100} = cfg[i];
            pause_time_10 = 16'h0000;
            free_buffers = 16'h0010;
            step(300);
            check(force_collision, !full_duplex && flow_enable);
            free_buffers = 16'h0040;
            step(3);
            check(force_collision, 1'b0);
        end
        // At the slow speed one quantum outlasts 1000 cycles.
        rx(PAUSE_DA, {CTRL_TYPE, PAUSE_OPCODE}, 16'h0001, 64, 1'b1, 1'b0);
        step(1000);
        check(paused, 1'b1);
        step(1100);
        check(paused, 1'b0);
        check(exp_rx.size(), 0);
        check(exp_tx.size(), 0);
        close_out();
    end
endmodule
`default_nettype wire
